// ---- shared/lmdc_pkg.sv ----
/*
  Constants and types of the long-mode descriptor checker: register map,
  field positions, type codes, descriptor classes and fault causes.
  Assumes a 32-bit APB register bus with byte addresses.
*/
`default_nettype none
package lmdc_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam int unsigned ADDR_W   = 8;
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_DW0   = 8'h04;
  localparam logic [7:0] OFF_DW1   = 8'h08;
  localparam logic [7:0] OFF_DW2   = 8'h0C;
  localparam logic [7:0] OFF_DW3   = 8'h10;
  localparam logic [7:0] OFF_SEL   = 8'h14;
  localparam logic [7:0] OFF_VEC   = 8'h18;
  localparam logic [7:0] OFF_TCS   = 8'h1C;
  localparam logic [7:0] OFF_PROBE = 8'h20;
  localparam logic [7:0] OFF_STAT  = 8'h24;
  localparam logic [7:0] OFF_OFFLO = 8'h28;
  localparam logic [7:0] OFF_OFFHI = 8'h2C;
  localparam logic [7:0] OFF_BASLO = 8'h30;
  localparam logic [7:0] OFF_BASHI = 8'h34;
  localparam logic [7:0] OFF_LIMIT = 8'h38;
  localparam logic [7:0] OFF_INFO  = 8'h3C;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ==========================================================
  // Register fields
  localparam int unsigned CTRL_START_BIT  = 0;
  localparam int unsigned CTRL_SUB64_BIT  = 1;
  localparam int unsigned CTRL_OP_LSB     = 2;
  localparam int unsigned TCS_LONG_BIT    = 0;
  localparam int unsigned TCS_DSIZE_BIT   = 1;
  localparam int unsigned ST_BUSY_BIT     = 0;
  localparam int unsigned ST_DONE_BIT     = 1;
  localparam int unsigned ST_FAULT_BIT    = 2;
  localparam int unsigned ST_CLASS_LSB    = 4;
  localparam int unsigned ST_CAUSE_LSB    = 8;
  localparam int unsigned ST_ERR_LSB      = 16;
  localparam int unsigned INFO_IDX_LSB    = 0;
  localparam int unsigned INFO_IDXSTK_BIT = 3;
  localparam int unsigned INFO_EXP_BIT    = 4;
  localparam int unsigned INFO_LT_BIT     = 5;
  localparam int unsigned INFO_TASK_BIT   = 6;
  localparam int unsigned INFO_SEL_LSB    = 16;

  // ==========================================================
  // Descriptor fields
  localparam int unsigned DESC_SYS_BIT  = 12;
  localparam int unsigned DESC_TYPE_LSB = 8;
  localparam int unsigned DESC_GRAN_BIT = 23;
  localparam int unsigned VA_BITS       = 48;
  localparam logic [11:0] GRAN_FILL     = 12'hFFF;
  localparam logic [3:0] TYPE_LT         = 4'h2;
  localparam logic [3:0] TYPE_TASK_AVAIL = 4'h9;
  localparam logic [3:0] TYPE_TASK_BUSY  = 4'hB;
  localparam logic [3:0] TYPE_CALL       = 4'hC;
  localparam logic [3:0] TYPE_INTR       = 4'hE;
  localparam logic [3:0] TYPE_TRAP       = 4'hF;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    OP_LOAD_LT   = 2'h0,
    OP_LOAD_TASK = 2'h1,
    OP_CALL      = 2'h2,
    OP_INTR      = 2'h3
  } lmdc_op_e;

  typedef enum logic [3:0] {
    CLS_ILLEGAL    = 4'h0,
    CLS_LT64       = 4'h1,
    CLS_LT32       = 4'h2,
    CLS_TASK_AVAIL = 4'h3,
    CLS_TASK_BUSY  = 4'h4,
    CLS_CALL       = 4'h5,
    CLS_INTR       = 4'h6,
    CLS_TRAP       = 4'h7
  } lmdc_class_e;

  typedef enum logic [3:0] {
    FLT_NONE   = 4'h0,
    FLT_TYPE   = 4'h1,
    FLT_KIND   = 4'h2,
    FLT_UPPER  = 4'h3,
    FLT_BASE   = 4'h4,
    FLT_LIMIT  = 4'h5,
    FLT_TARGET = 4'h6,
    FLT_OFFSET = 4'h7
  } lmdc_cause_e;
endpackage
`default_nettype wire

// ---- shared/lmdc_dec_if.sv ----
/*
  Carrier between the checker and its type decoder.
  Assumes both ends sit in the same clock domain; content is combinational.
*/
`timescale 1ns/1ps
`default_nettype none
interface lmdc_dec_if
  import lmdc_pkg::*;
();
  logic [3:0]  type_code;
  logic        sys_bit;
  logic        sub64;
  lmdc_class_e cls;
  logic        illegal;

  modport decoder (input type_code, input sys_bit, input sub64, output cls, output illegal);
  modport user    (output type_code, output sys_bit, output sub64, input cls, input illegal);
endinterface
`default_nettype wire

// ---- logic/lmdc_type_decoder.sv ----
/*
  Long-mode type decoder: classifies the 4-bit type of a system or gate
  descriptor. Assumes type and S bit come from the descriptor's second dword.
*/
`timescale 1ns/1ps
`default_nettype none
module lmdc_type_decoder
  import lmdc_pkg::*;
(
  lmdc_dec_if.decoder dec
);
  // ==========================================================
  // Classification
  always_comb begin
    unique case (dec.type_code)
      TYPE_LT:         dec.cls = dec.sub64 ? CLS_LT64 : CLS_LT32;
      TYPE_TASK_AVAIL: dec.cls = CLS_TASK_AVAIL;
      TYPE_TASK_BUSY:  dec.cls = CLS_TASK_BUSY;
      TYPE_CALL:       dec.cls = CLS_CALL;
      TYPE_INTR:       dec.cls = CLS_INTR;
      TYPE_TRAP:       dec.cls = CLS_TRAP;
      // 0, 1, 3-8, A, D: includes the 16-bit gates and the task gate
      default:         dec.cls = CLS_ILLEGAL;
    endcase
  end

  // Code and data segments (S set) are never valid here
  assign dec.illegal = (dec.cls == CLS_ILLEGAL) | dec.sys_bit;
endmodule
`default_nettype wire

// ---- logic/lmdc_checker.sv ----
/*
  Long-mode system and gate descriptor checker with an APB register port.
  Software loads the descriptor dwords, selector, vector and target code
  segment attributes, then starts a check; results appear in status regs.
  Assumes a single clock and an APB master following the usual protocol.
*/
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module lmdc_checker
  import lmdc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             general_protection_fault,
  output logic             check_done
);
  // ==========================================================
  // Types and functions
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_CHECK = 2'b10
  } lmdc_state_e;

  function automatic logic is_canonical(input logic [63:0] addr);
    logic [64-VA_BITS:0] top;
    top = addr[63:VA_BITS-1];
    return (top == '0) || (top == '1);
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    return (addr[1:0] == 2'h0) && (addr <= OFF_INFO);
  endfunction

  // ==========================================================
  // Declarations
  lmdc_state_e  state_reg;
  logic [31:0]  dw_reg [4];
  logic         sub64_reg;
  lmdc_op_e     op_reg;
  logic [15:0]  sel_reg;
  logic [7:0]   vec_reg;
  logic [1:0]   tcs_reg;
  logic [31:0]  probe_reg;
  logic         done_reg;
  logic         fault_reg;
  lmdc_cause_e  cause_reg;
  lmdc_class_e  class_reg;
  logic [15:0]  err_reg;
  logic [63:0]  offset_reg;
  logic [63:0]  base_reg;
  logic [31:0]  limit_reg;
  logic [2:0]   idx_reg;
  logic [15:0]  tsel_reg;
  logic         exp_reg;
  logic         lt_loaded_reg;
  logic         task_loaded_reg;
  logic         access_ok;
  logic         commit;
  logic         start_req;
  logic [31:0]  rdata_next;
  lmdc_cause_e  cause_next;
  logic [15:0]  err_next;
  logic [63:0]  offset_next;
  logic [63:0]  base_next;
  logic [31:0]  limit_next;
  logic [2:0]   idx_next;
  logic         exp_next;
  logic         is_gate;
  logic         kind_ok;
  logic [19:0]  raw_limit;
  logic [31:0]  base_low;

  lmdc_dec_if dec ();

  lmdc_type_decoder u_dec (
    .dec (dec.decoder)
  );

  // ==========================================================
  // APB slave
  // Access phase lasts two cycles; the write lands when pready is seen high
  assign access_ok = psel & penable & ~pready;
  assign commit    = psel & penable & pready;
  assign start_req = commit & pwrite & (paddr == OFF_CTRL) & pwdata[CTRL_START_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RST_WORD;
    end else begin
      pready  <= access_ok;
      pslverr <= access_ok & ~is_mapped(paddr);
      if (access_ok && !pwrite) begin
        prdata <= rdata_next;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub64_reg <= 1'b0;
      op_reg    <= OP_LOAD_LT;
      sel_reg   <= '0;
      vec_reg   <= '0;
      tcs_reg   <= '0;
      probe_reg <= RST_WORD;
      for (int i = 0; i < 4; i++) begin
        dw_reg[i] <= RST_WORD;
      end
    end else if (commit && pwrite) begin
      unique case (paddr)
        OFF_CTRL: begin
          sub64_reg <= pwdata[CTRL_SUB64_BIT];
          op_reg    <= lmdc_op_e'(pwdata[CTRL_OP_LSB +: 2]);
        end
        OFF_DW0:   dw_reg[0] <= pwdata;
        OFF_DW1:   dw_reg[1] <= pwdata;
        OFF_DW2:   dw_reg[2] <= pwdata;
        OFF_DW3:   dw_reg[3] <= pwdata;
        OFF_SEL:   sel_reg   <= pwdata[15:0];
        OFF_VEC:   vec_reg   <= pwdata[7:0];
        OFF_TCS:   tcs_reg   <= pwdata[1:0];
        OFF_PROBE: probe_reg <= pwdata;
        // Status and result words are read-only; unmapped writes dropped
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata_next = RST_WORD;
    unique case (paddr)
      OFF_CTRL: begin
        rdata_next[CTRL_SUB64_BIT]     = sub64_reg;
        rdata_next[CTRL_OP_LSB +: 2]   = op_reg;
      end
      OFF_DW0:   rdata_next = dw_reg[0];
      OFF_DW1:   rdata_next = dw_reg[1];
      OFF_DW2:   rdata_next = dw_reg[2];
      OFF_DW3:   rdata_next = dw_reg[3];
      OFF_SEL:   rdata_next[15:0] = sel_reg;
      OFF_VEC:   rdata_next[7:0]  = vec_reg;
      OFF_TCS:   rdata_next[1:0]  = tcs_reg;
      OFF_PROBE: rdata_next = probe_reg;
      OFF_STAT: begin
        rdata_next[ST_BUSY_BIT]       = (state_reg == ST_CHECK);
        rdata_next[ST_DONE_BIT]       = done_reg;
        rdata_next[ST_FAULT_BIT]      = fault_reg;
        rdata_next[ST_CLASS_LSB +: 4] = class_reg;
        rdata_next[ST_CAUSE_LSB +: 4] = cause_reg;
        rdata_next[ST_ERR_LSB +: 16]  = err_reg;
      end
      OFF_OFFLO: rdata_next = offset_reg[31:0];
      OFF_OFFHI: rdata_next = offset_reg[63:32];
      OFF_BASLO: rdata_next = base_reg[31:0];
      OFF_BASHI: rdata_next = base_reg[63:32];
      OFF_LIMIT: rdata_next = limit_reg;
      OFF_INFO: begin
        rdata_next[INFO_IDX_LSB +: 3]  = idx_reg;
        rdata_next[INFO_IDXSTK_BIT]    = (idx_reg != 3'h0);
        rdata_next[INFO_EXP_BIT]       = exp_reg;
        rdata_next[INFO_LT_BIT]        = lt_loaded_reg;
        rdata_next[INFO_TASK_BIT]      = task_loaded_reg;
        rdata_next[INFO_SEL_LSB +: 16] = tsel_reg;
      end
      default: rdata_next = RST_WORD;
    endcase
  end

  // ==========================================================
  // Descriptor decode
  assign dec.type_code = dw_reg[1][DESC_TYPE_LSB +: 4];
  assign dec.sys_bit   = dw_reg[1][DESC_SYS_BIT];
  assign dec.sub64     = sub64_reg;

  assign is_gate = (op_reg == OP_CALL) || (op_reg == OP_INTR);
  // Gates expand in both submodes, system entries only in 64-bit submode
  assign exp_next = is_gate | sub64_reg;

  assign raw_limit  = {dw_reg[1][19:16], dw_reg[0][15:0]};
  assign limit_next = dw_reg[1][DESC_GRAN_BIT] ? {raw_limit, GRAN_FILL}
                                               : {12'h000, raw_limit};
  assign base_low   = {dw_reg[1][31:24], dw_reg[1][7:0], dw_reg[0][31:16]};
  // Compatibility submode reads system entries in the legacy 8-byte layout only
  assign base_next  = sub64_reg ? {dw_reg[2], base_low} : {32'h0000_0000, base_low};
  assign offset_next = {dw_reg[2], dw_reg[1][31:16], dw_reg[0][15:0]};
  // Call gates carry no stack index; those bits are reserved there
  assign idx_next = (dec.cls == CLS_INTR || dec.cls == CLS_TRAP) ? dw_reg[1][2:0]
                                                                 : 3'h0;

  always_comb begin
    unique case (op_reg)
      OP_LOAD_LT:   kind_ok = (dec.cls == CLS_LT64) || (dec.cls == CLS_LT32);
      OP_LOAD_TASK: kind_ok = (dec.cls == CLS_TASK_AVAIL);
      OP_CALL:      kind_ok = (dec.cls == CLS_CALL);
      OP_INTR:      kind_ok = (dec.cls == CLS_INTR) || (dec.cls == CLS_TRAP);
    endcase
  end

  // ==========================================================
  // Fault priority
  // Reserved-ignore bits (dword3 outside 12-8, low bytes) are never examined
  always_comb begin
    cause_next = FLT_NONE;
    err_next   = (op_reg == OP_INTR) ? {8'h00, vec_reg} : sel_reg;
    if (dec.illegal) begin
      // Upper half of a 16-byte entry reads as type 0 and lands here
      cause_next = FLT_TYPE;
    end else if (!kind_ok) begin
      cause_next = FLT_KIND;
    end else if ((op_reg == OP_CALL || (!is_gate && sub64_reg))
                 && dw_reg[3][12:8] != 5'h00) begin
      cause_next = FLT_UPPER;
    end else if (!is_gate) begin
      if (!is_canonical(base_next)) begin
        cause_next = FLT_BASE;
        err_next   = sel_reg;
      end else if (probe_reg > limit_next) begin
        cause_next = FLT_LIMIT;
        err_next   = sel_reg;
      end
    end else if (!tcs_reg[TCS_LONG_BIT] || tcs_reg[TCS_DSIZE_BIT]) begin
      cause_next = FLT_TARGET;
    end else if (!is_canonical(offset_next)) begin
      cause_next = FLT_OFFSET;
      err_next   = 16'h0000;
    end
  end

  // ==========================================================
  // Check sequencing
  // A start while a check runs is dropped; the check takes one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE:  state_reg <= start_req ? ST_CHECK : ST_IDLE;
        ST_CHECK: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg   <= 1'b0;
      check_done <= 1'b0;
    end else begin
      check_done <= (state_reg == ST_CHECK);
      if (state_reg == ST_CHECK) begin
        done_reg <= 1'b1;
      end else if (start_req) begin
        done_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_reg                <= 1'b0;
      general_protection_fault <= 1'b0;
      cause_reg                <= FLT_NONE;
      class_reg                <= CLS_ILLEGAL;
      err_reg                  <= '0;
    end else if (state_reg == ST_CHECK) begin
      fault_reg                <= (cause_next != FLT_NONE);
      general_protection_fault <= (cause_next != FLT_NONE);
      cause_reg                <= cause_next;
      class_reg                <= dec.illegal ? CLS_ILLEGAL : dec.cls;
      err_reg                  <= (cause_next == FLT_NONE) ? 16'h0000 : err_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_reg <= '0;
      base_reg   <= '0;
      limit_reg  <= RST_WORD;
      idx_reg    <= '0;
      tsel_reg   <= '0;
      exp_reg    <= 1'b0;
    end else if (state_reg == ST_CHECK) begin
      exp_reg <= exp_next;
      if (is_gate) begin
        offset_reg <= offset_next;
        tsel_reg   <= dw_reg[0][31:16];
        idx_reg    <= idx_next;
        base_reg   <= '0;
        limit_reg  <= RST_WORD;
      end else begin
        offset_reg <= '0;
        tsel_reg   <= '0;
        idx_reg    <= 3'h0;
        base_reg   <= base_next;
        limit_reg  <= limit_next;
      end
    end
  end

  // A good load marks the matching table register as holding a descriptor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lt_loaded_reg   <= 1'b0;
      task_loaded_reg <= 1'b0;
    end else if (state_reg == ST_CHECK && cause_next == FLT_NONE) begin
      if (op_reg == OP_LOAD_LT) begin
        lt_loaded_reg <= 1'b1;
      end
      if (op_reg == OP_LOAD_TASK) begin
        task_loaded_reg <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/lmdc_checker_asserts.sv ----
/*
  Port-level assertions for lmdc_checker, bound to every instance.
  Assumes an APB master that holds each request until pready.
*/
`timescale 1ns/1ps
`default_nettype none
module lmdc_checker_asserts
  import lmdc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        general_protection_fault,
  input wire logic        check_done
);
  // ==========================================================
  // Helpers
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready;
  wire bad = paddr > 8'h3C || paddr[1:0] != 2'h0;
  wire start = acc && pwrite && paddr == OFF_CTRL && pwdata[CTRL_START_BIT];

  // ==========================================================
  // Assertions
  a_start_done: assert property (start |-> ##[1:3] check_done)
    else $error("no check_done after start");
  a_done_pulse: assert property (check_done |=> !check_done)
    else $error("check_done longer than one cycle");
  a_fault_hold: assert property ($changed(general_protection_fault) |-> check_done)
    else $error("fault pin moved outside check end");
  a_ready_time: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_qual: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_err_bad: assert property (acc && bad |-> pslverr)
    else $error("unmapped access without pslverr");
  a_err_good: assert property (acc && !bad |-> !pslverr)
    else $error("mapped access with pslverr");
  a_err_zero: assert property (acc && bad && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read data not zero");

  c_fault: cover property (check_done && general_protection_fault);
  c_clean: cover property (check_done && !general_protection_fault);
  c_slverr: cover property (pready && pslverr);
endmodule

bind lmdc_checker lmdc_checker_asserts lmdc_checker_asserts_inst (
  .pclk                     (pclk),
  .presetn                  (presetn),
  .psel                     (psel),
  .penable                  (penable),
  .pwrite                   (pwrite),
  .paddr                    (paddr),
  .pwdata                   (pwdata),
  .prdata                   (prdata),
  .pready                   (pready),
  .pslverr                  (pslverr),
  .general_protection_fault (general_protection_fault),
  .check_done               (check_done)
);
`default_nettype wire

// ---- dv/lmdc_desc_table.sv ----
/*
  Descriptor table model: long-mode entries that the bench loads.
  Assumes the reader holds idx one cycle before using entry.
*/
`timescale 1ns/1ps
`default_nettype none
module lmdc_desc_table
  import lmdc_pkg::*;
(
  input  wire logic [3:0]   idx,
  output logic      [127:0] entry
);
  // ==========================================================
  // Entries as {dword +12, +8, +4, +0}
  logic [127:0] mem [16];
  assign entry = mem[idx];
  initial begin
    mem = '{default: 128'h0};
    // Interrupt gate upper half need not be clear
    mem[0] = {32'hFFFF_FFFF, 32'h0000_7FFF, 32'h9ABC_8E03, 32'h1234_5678};
    mem[1] = {32'h0000_0000, 32'h0000_7FFF, 32'h9ABC_8C03, 32'h1234_5678};
    mem[2] = {32'h0000_0000, 32'h0000_8000, 32'h9ABC_8E03, 32'h1234_5678};
    mem[3] = {64'h0, 32'h0000_8F00, 32'h0050_0000};
    mem[4] = {64'h0, 32'h0000_8C00, 32'h0050_0000};
    // Entries 5 and 6 break the clear upper type bits on purpose
    mem[5] = {32'h0000_0100, 32'h0, 32'h0000_8C00, 32'h0050_0000};
    mem[6] = {32'h0000_1F00, 32'h0, 32'h0000_8200, 32'h0};
    mem[7] = {32'hFFFF_E0FF, 32'h0000_1234, 32'hAA00_89CC, 32'hBEEF_0010};
    mem[8] = {32'h0000_0000, 32'h0000_8000, 32'hAA00_89CC, 32'hBEEF_0010};
    mem[9] = {32'h0000_1F00, 32'h0000_8000, 32'hAA00_89CC, 32'hBEEF_0010};
    mem[10] = {64'h0, 32'h0000_8200, 32'h0000_0010};
    mem[11] = {64'h0, 32'h0080_8200, 32'h0000_0010};
    mem[12] = {64'h0, 32'h0000_9900, 32'h0};
  end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
/*
  Self-checking bench for lmdc_checker: APB tasks load descriptors and
  compare status and result registers with expected values.
  Assumes the assertion file binds its assertions to the design.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import lmdc_pkg::*;
;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         general_protection_fault;
  logic         check_done;
  logic [3:0]   idx = 4'h0;
  logic [127:0] entry;
  int           failures = 0;
  int           tests_run = 0;
  logic [3:0]   tcls [16] = '{4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
                              4'h0, 4'h3, 4'h0, 4'h4, 4'h5, 4'h0, 4'h6, 4'h7};
  logic [1:0]   tops [16] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
                              2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h0, 2'h3, 2'h3};

  lmdc_checker lmdc_checker_inst (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .general_protection_fault (general_protection_fault),
    .check_done               (check_done)
  );
  lmdc_desc_table lmdc_desc_table_inst (.idx(idx), .entry(entry));

  initial begin
    forever #5 pclk = ~pclk;
  end

  // ==========================================================
  // Tasks
  task automatic print_verdict();
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // An idle cycle after each transfer keeps one assignment per signal per edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic        e;
    apb(1'b1, a, d, v, e);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                      input string what);
    logic [31:0] v;
    logic        e;
    apb(1'b0, a, 32'h0, v, e);
    chk(what, v & m, x);
  endtask

  task automatic run(input logic [127:0] d, input logic [1:0] op, input logic s,
                     input logic [1:0] tcs, input logic [7:0] pr, input logic [3:0] c,
                     input logic [3:0] f, input logic [15:0] er);
    logic [31:0] st;
    logic        e;
    int          n;
    for (int k = 0; k < 4; k++) begin
      wr(OFF_DW0 + 8'(4 * k), d[32 * k +: 32]);
    end
    wr(OFF_TCS, {30'h0, tcs});
    wr(OFF_PROBE, {24'h0, pr});
    wr(OFF_CTRL, {28'h0, op, s, 1'b1});
    n = 0;
    do begin
      apb(1'b0, OFF_STAT, 32'h0, st, e);
      n++;
    end while (st[ST_DONE_BIT] !== 1'b1 && n < 10);
    chk("status", st, {er, 4'h0, f, c, 1'b0, f != 4'h0, 2'b10});
    chk("fault pin", {31'h0, general_protection_fault}, {31'h0, f != 4'h0});
    if (n >= 10) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic tcase(input logic [3:0] i, input logic [1:0] op, input logic s,
                       input logic [1:0] tcs, input logic [7:0] pr, input logic [3:0] c,
                       input logic [3:0] f, input logic [15:0] er);
    idx <= i;
    @(posedge pclk);
    run(entry, op, s, tcs, pr, c, f, er);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0]  v;
    logic         e;
    logic [3:0]   c;
    logic [3:0]   f;
    logic [15:0]  er;
    logic [127:0] d;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 64; a += 4) begin
      rchk(8'(a), 32'hFFFF_FFFF, 32'h0, "reset value");
    end
    wr(OFF_SEL, 32'h0000_0050);
    wr(OFF_VEC, 32'h0000_0021);
    for (int s = 0; s < 2; s++) begin
      for (int t = 0; t < 16; t++) begin
        c = (t == 2 && s == 0) ? 4'h2 : tcls[t];
        f = (tcls[t] == 4'h0) ? 4'h1 : (t == 11) ? 4'h2 : 4'h0;
        er = (f != 4'h0) ? 16'h0050 : 16'h0;
        d = {64'h0, 32'h0000_8000, 32'h0} | (128'(t) << 40);
        run(d, tops[t], s[0], 2'h1, 8'h0, c, f, er);
      end
    end
    tcase(4'h0, OP_INTR, 1'b1, 2'h1, 8'h0, CLS_INTR, FLT_NONE, 16'h0);
    rchk(OFF_OFFLO, 32'hFFFF_FFFF, 32'h9ABC_5678, "offset lo");
    rchk(OFF_OFFHI, 32'hFFFF_FFFF, 32'h0000_7FFF, "offset hi");
    rchk(OFF_INFO, 32'hFFFF_000F, 32'h1234_000B, "gate info");
    tcase(4'h1, OP_CALL, 1'b1, 2'h1, 8'h0, CLS_CALL, FLT_NONE, 16'h0);
    rchk(OFF_INFO, 32'h0000_000F, 32'h0, "call index");
    tcase(4'h2, OP_INTR, 1'b0, 2'h1, 8'h0, CLS_INTR, FLT_OFFSET, 16'h0);
    tcase(4'h3, OP_INTR, 1'b1, 2'h3, 8'h0, CLS_TRAP, FLT_TARGET, 16'h0021);
    tcase(4'h4, OP_CALL, 1'b1, 2'h0, 8'h0, CLS_CALL, FLT_TARGET, 16'h0050);
    tcase(4'h5, OP_CALL, 1'b1, 2'h1, 8'h0, CLS_CALL, FLT_UPPER, 16'h0050);
    tcase(4'h6, OP_LOAD_LT, 1'b1, 2'h1, 8'h0, CLS_LT64, FLT_UPPER, 16'h0050);
    tcase(4'h7, OP_LOAD_TASK, 1'b1, 2'h1, 8'h10, CLS_TASK_AVAIL, FLT_NONE, 16'h0);
    rchk(OFF_BASLO, 32'hFFFF_FFFF, 32'hAACC_BEEF, "base lo");
    rchk(OFF_BASHI, 32'hFFFF_FFFF, 32'h0000_1234, "base hi");
    rchk(OFF_INFO, 32'h0000_0050, 32'h0000_0050, "task expanded");
    tcase(4'h8, OP_LOAD_TASK, 1'b1, 2'h1, 8'h10, CLS_TASK_AVAIL, FLT_BASE, 16'h0050);
    tcase(4'h9, OP_LOAD_TASK, 1'b0, 2'h1, 8'h10, CLS_TASK_AVAIL, FLT_NONE, 16'h0);
    rchk(OFF_INFO, 32'h0000_0010, 32'h0, "legacy format");
    tcase(4'hA, OP_LOAD_LT, 1'b0, 2'h1, 8'h11, CLS_LT32, FLT_LIMIT, 16'h0050);
    tcase(4'hB, OP_LOAD_LT, 1'b1, 2'h1, 8'h11, CLS_LT64, FLT_NONE, 16'h0);
    rchk(OFF_LIMIT, 32'hFFFF_FFFF, 32'h0001_0FFF, "scaled limit");
    tcase(4'hC, OP_LOAD_TASK, 1'b1, 2'h1, 8'h0, CLS_ILLEGAL, FLT_TYPE, 16'h0050);
    apb(1'b0, 8'h40, 32'h0, v, e);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", v, 32'h0);
    apb(1'b1, 8'h06, 32'hFFFF_FFFF, v, e);
    chk("misaligned err", {31'h0, e}, 32'h1);
    // Status is read-only, so the last check result must survive this write
    wr(OFF_STAT, 32'hFFFF_FFFF);
    rchk(OFF_STAT, 32'hFFFF_FFFF, 32'h0050_0106, "status read-only");
    print_verdict();
  end
endmodule
`default_nettype wire
